/* File: logic/ccfg_top.sv */
`timescale 1ns/1ns
module ccfg_top
#(
	parameter int SCAN_CYCLES = ccfg_pkg::SCAN_UNIT_CYCLES
)
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  reset_in,
	input  wire ccfg_pkg::ccfg_req_s   reg_req_in,
	output logic [7:0]                 reg_rdata_out,
	output logic                       reg_rvalid_out,
	input  wire logic                  solar_powered_in,
	input  wire ccfg_pkg::ccfg_stage_e stage_in,
	input  wire logic                  stage_scan_event_in,
	input  wire logic [15:0]           stage2_voltage_at_25c_in,
	input  wire logic [15:0]           stage3_voltage_at_25c_in,
	input  wire logic [15:0]           temperature_scale_factor_in,
	output logic                       scan_request_out,
	output logic                       low_power_enable_out,
	output logic                       stage3_allowed_out,
	output logic                       comp_active_out,
	output ccfg_pkg::ccfg_coeff_s      coeff_out,
	output ccfg_pkg::ccfg_volt_s       volt_out,
	output logic                       battery_feedback_adjust_pin_out
);
	import ccfg_pkg::*;

	// register file
	logic [7:0]  lowpower_scan_period;
	logic [7:0]  solar_scan_period;
	logic [7:0]  charge_misc_control;
	logic [31:0] temp_coeff_third_order;
	logic [31:0] temp_coeff_second_order;
	logic [31:0] temp_coeff_first_order;

	// address decode; boot addresses are read only
	wire logic [7:0] boot_addr = reg_req_in.addr - BOOT_OFFSET;
	wire logic       is_boot   = reg_req_in.addr >= BOOT_OFFSET;
	wire logic [7:0] rd_addr   = is_boot ? boot_addr : reg_req_in.addr;
	wire logic       wr_ok     = reg_req_in.wr && !is_boot;
	wire logic       wr_lp     = wr_ok && reg_req_in.addr == ADDR_LP_SCAN;
	wire logic       wr_scan   = wr_ok && reg_req_in.addr == ADDR_SCAN;
	wire logic       wr_misc   = wr_ok && reg_req_in.addr == ADDR_MISC;
	wire logic       wr_tc     = wr_ok && reg_req_in.addr >= ADDR_TC3
		&& reg_req_in.addr <= ADDR_TC_LAST;
	wire logic [7:0] tc_off    = reg_req_in.addr - ADDR_TC3;
	wire logic [1:0] tc_sel    = tc_off[3:2];
	wire logic [1:0] tc_byte   = tc_off[1:0];

	// byte write into a long-word, low byte at lowest address
	function automatic logic [31:0] put_byte(
		input logic [31:0] word,
		input logic [1:0]  lane,
		input logic [7:0]  data
	);
		logic [31:0] res;
		res = word;
		res[{lane, 3'h0} +: 8] = data;
		return res;
	endfunction

	wire logic [31:0] next_tc3 =
		put_byte(temp_coeff_third_order, tc_byte, reg_req_in.wdata);
	wire logic [31:0] next_tc2 =
		put_byte(temp_coeff_second_order, tc_byte, reg_req_in.wdata);
	wire logic [31:0] next_tc1 =
		put_byte(temp_coeff_first_order, tc_byte, reg_req_in.wdata);

	// scan period and control byte writes
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			lowpower_scan_period <= RST_LP_SCAN;
			solar_scan_period    <= RST_SCAN;
			charge_misc_control  <= RST_MISC;
		end
		else
		begin
			if (wr_lp)
				lowpower_scan_period <= reg_req_in.wdata;
			if (wr_scan)
				solar_scan_period <= reg_req_in.wdata;
			if (wr_misc)
				charge_misc_control <= reg_req_in.wdata & MISC_WR_MASK;
		end
	end

	// coefficient long-word writes, one byte at a time
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			temp_coeff_third_order  <= RST_TC;
			temp_coeff_second_order <= RST_TC;
			temp_coeff_first_order  <= RST_TC;
		end
		else if (wr_tc)
		begin
			case (tc_sel)
				2'h0:    temp_coeff_third_order  <= next_tc3;
				2'h1:    temp_coeff_second_order <= next_tc2;
				2'h2:    temp_coeff_first_order  <= next_tc1;
				default: temp_coeff_first_order  <= temp_coeff_first_order;
			endcase
		end
	end

	// read mux over normal and boot addresses
	wire logic [7:0] rd_tc_off = rd_addr - ADDR_TC3;
	wire logic       rd_is_tc  = rd_addr >= ADDR_TC3 && rd_addr <= ADDR_TC_LAST;
	logic [31:0] rd_word;
	logic [7:0]  next_rdata;

	always_comb
	begin
		case (rd_tc_off[3:2])
			2'h0:    rd_word = temp_coeff_third_order;
			2'h1:    rd_word = temp_coeff_second_order;
			default: rd_word = temp_coeff_first_order;
		endcase
		if (rd_is_tc)
			next_rdata = rd_word[{rd_tc_off[1:0], 3'h0} +: 8];
		else if (rd_addr == ADDR_LP_SCAN)
			next_rdata = lowpower_scan_period;
		else if (rd_addr == ADDR_SCAN)
			next_rdata = solar_scan_period;
		else if (rd_addr == ADDR_MISC)
			next_rdata = charge_misc_control;
		else
			next_rdata = 8'h00;
	end

	// read data registered, one cycle after the strobe
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= reg_req_in.rd;
			if (reg_req_in.rd)
				reg_rdata_out <= next_rdata;
		end
	end

	// control byte fields
	wire logic reduced_stage2_voltage = charge_misc_control[BIT_RED_S2];
	wire logic low_power_enable       = charge_misc_control[BIT_LP_EN];
	wire logic dc_stage3_enable       = charge_misc_control[BIT_DC_S3];
	wire logic solar_stage3_enable    = charge_misc_control[BIT_SOLAR_S3];
	wire logic temp_comp_enable       = charge_misc_control[BIT_TC_EN];

	assign low_power_enable_out = low_power_enable;
	assign stage3_allowed_out   = solar_powered_in ? solar_stage3_enable
		: dc_stage3_enable;

	// timed scan: active period chosen by low power mode
	wire logic [7:0] active_period = low_power_enable ? lowpower_scan_period
		: solar_scan_period;
	wire logic timer_run = solar_powered_in && active_period != 8'h00;
	logic [31:0] tick_count;
	logic [7:0]  unit_count;
	logic        mode_seen;
	logic        startup_pending;
	wire logic tick_done  = tick_count == 32'(SCAN_CYCLES - 1);
	wire logic scan_due   = tick_done && unit_count == active_period - 8'h01;
	wire logic mode_moved = mode_seen != low_power_enable;

	// tick and unit counters restart on mode change or when halted
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			tick_count <= 32'h0000_0000;
			unit_count <= 8'h00;
			mode_seen  <= 1'b0;
		end
		else
		begin
			mode_seen <= low_power_enable;
			if (!timer_run || mode_moved || scan_due)
			begin
				tick_count <= 32'h0000_0000;
				unit_count <= 8'h00;
			end
			else if (tick_done)
			begin
				tick_count <= 32'h0000_0000;
				unit_count <= unit_count + 8'h01;
			end
			else
				tick_count <= tick_count + 32'h0000_0001;
		end
	end

	// startup scan waits until solar power is seen
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
			startup_pending <= 1'b1;
		else if (solar_powered_in)
			startup_pending <= 1'b0;
	end

	// scan request pulse; nothing at all without solar supply
	wire logic next_scan = solar_powered_in
		&& ((timer_run && !mode_moved && scan_due)
		|| startup_pending || stage_scan_event_in);

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
			scan_request_out <= 1'b0;
		else
			scan_request_out <= next_scan;
	end

	// compensation gating and coefficient hand-off
	wire logic in_comp_stage = stage_in == STG_S2 || stage_in == STG_S3;
	wire logic comp_on = temp_comp_enable && in_comp_stage;
	wire logic [15:0] factor = comp_on ? temperature_scale_factor_in
		: FACTOR_ONE;

	assign comp_active_out = comp_on;
	assign coeff_out = {temp_coeff_third_order,
		temp_coeff_second_order, temp_coeff_first_order};

	// scale a 25 C target by the factor, saturating
	function automatic logic [15:0] scale(
		input logic [15:0] v25,
		input logic [15:0] fac
	);
		logic [31:0] prod;
		prod = v25 * fac;
		if (prod[31:30] != 2'h0)
			return 16'hffff;
		return prod[FACTOR_FRAC +: 16];
	endfunction

	// percentage of a reference voltage
	function automatic logic [15:0] pct(
		input logic [15:0] ref_v,
		input logic [6:0]  p
	);
		logic [22:0] prod;
		prod = ref_v * p;
		return 16'(prod / 23'(PCT_FULL));
	endfunction

	wire logic [15:0] vs2_comp =
		scale(stage2_voltage_at_25c_in, factor);
	wire logic [15:0] vs3_comp =
		scale(stage3_voltage_at_25c_in, factor);
	wire logic [15:0] stage2_ref = reduced_stage2_voltage ? vs3_comp
		: vs2_comp;

	ccfg_volt_s next_volt;
	assign next_volt.stage2_target = stage2_ref;
	assign next_volt.stage3_target = vs3_comp;
	assign next_volt.s1_to_s2 = pct(stage2_ref, PCT_UP);
	assign next_volt.s2_to_s1 = pct(stage2_ref, PCT_DOWN);
	assign next_volt.base_ref = vs2_comp;

	// registered voltage targets and thresholds
	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
			volt_out <= '0;
		else
			volt_out <= next_volt;
	end

	// feedback adjust pwm: duty follows the factor
	logic [7:0]  pwm_count;
	wire logic [23:0] duty_prod = DUTY_NOMINAL * factor;
	wire logic [7:0]  duty = duty_prod[23:22] != 2'h0 ? 8'hff
		: duty_prod[FACTOR_FRAC +: 8];

	always_ff @(posedge clk_sys_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			pwm_count <= 8'h00;
			battery_feedback_adjust_pin_out <= 1'b0;
		end
		else
		begin
			pwm_count <= pwm_count + 8'h01;
			battery_feedback_adjust_pin_out <= pwm_count < duty;
		end
	end

endmodule

/* File: logic/ccfg_pkg.sv */
package ccfg_pkg;

	// register addresses
	localparam logic [7:0] ADDR_LP_SCAN  = 8'h4b;
	localparam logic [7:0] ADDR_SCAN     = 8'h4c;
	localparam logic [7:0] ADDR_MISC     = 8'h4d;
	localparam logic [7:0] ADDR_TC3      = 8'h4e;
	localparam logic [7:0] ADDR_TC2      = 8'h52;
	localparam logic [7:0] ADDR_TC1      = 8'h56;
	localparam logic [7:0] ADDR_TC_LAST  = 8'h59;
	localparam logic [7:0] BOOT_OFFSET   = 8'h60;

	// control byte fields
	localparam int BIT_TC_EN     = 0;
	localparam int BIT_SOLAR_S3  = 1;
	localparam int BIT_DC_S3     = 2;
	localparam int BIT_LP_EN     = 3;
	localparam int BIT_RED_S2    = 4;
	localparam logic [7:0] MISC_WR_MASK = 8'h1f;

	// reset values
	localparam logic [7:0]  RST_LP_SCAN = 8'h00;
	localparam logic [7:0]  RST_SCAN    = 8'h00;
	localparam logic [7:0]  RST_MISC    = 8'h00;
	localparam logic [31:0] RST_TC      = 32'h0000_0000;

	// scan period unit: 16.66 s, kept in ms, cycles at 20 MHz
	localparam longint SCAN_UNIT_MS = 16660;
	localparam longint CLK_KHZ      = 20000;
	localparam int     SCAN_UNIT_CYCLES = int'(SCAN_UNIT_MS * CLK_KHZ);

	// threshold percentages and factor format (unity = 1 << 14)
	localparam logic [6:0]  PCT_UP      = 7'h62;
	localparam logic [6:0]  PCT_DOWN    = 7'h5f;
	localparam logic [6:0]  PCT_FULL    = 7'h64;
	localparam int          FACTOR_FRAC = 14;
	localparam logic [15:0] FACTOR_ONE  = 16'h4000;
	localparam logic [7:0]  DUTY_NOMINAL = 8'h80;

	typedef enum logic [2:0] {
		STG_UV   = 3'h0,
		STG_S0   = 3'h1,
		STG_S1   = 3'h3,
		STG_S2   = 3'h2,
		STG_S3   = 3'h6,
		STG_DONE = 3'h7
	} ccfg_stage_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccfg_req_s;

	typedef struct packed {
		logic        sign;
		logic [7:0]  exponent;
		logic [22:0] mantissa;
	} ccfg_float_s;

	typedef struct packed {
		ccfg_float_s tc3;
		ccfg_float_s tc2;
		ccfg_float_s tc1;
	} ccfg_coeff_s;

	typedef struct packed {
		logic [15:0] stage2_target;
		logic [15:0] stage3_target;
		logic [15:0] s1_to_s2;
		logic [15:0] s2_to_s1;
		logic [15:0] base_ref;
	} ccfg_volt_s;

endpackage

/* File: verif/ccfg_host_model.sv */
`timescale 1ns/1ns
module ccfg_host_model
	import ccfg_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output ccfg_pkg::ccfg_req_s req_out
);
	// idle bus shows inverted last values, never a stale match
	initial req_out = '{1'b0, 1'b0, 8'h00, 8'h00};

	// one byte write, strobe held for one clock
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		if (a == ADDR_MISC && d[4])
			d[2:1] = 2'b00;
		req_out = '{1'b1, 1'b0, a, d};
		@(negedge clk_in);
		req_out = '{1'b0, 1'b0, ~a, ~d};
	endtask

	// one byte read, answer taken with the valid pulse
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		req_out = '{1'b0, 1'b1, a, ~a};
		@(negedge clk_in);
		req_out = '{1'b0, 1'b0, ~a, a};
		d = rvalid_in ? rdata_in : ~rdata_in;
	endtask
endmodule

/* File: verif/ccfg_properties.sv */
`timescale 1ns/1ns
module ccfg_properties
	import ccfg_pkg::*;
#(
	parameter int SCAN_CYCLES = 4
)
(
	input wire logic                  clk_sys_in,
	input wire logic                  reset_in,
	input wire ccfg_pkg::ccfg_req_s   reg_req_in,
	input wire logic [7:0]            reg_rdata_out,
	input wire logic                  reg_rvalid_out,
	input wire logic                  solar_powered_in,
	input wire ccfg_pkg::ccfg_stage_e stage_in,
	input wire logic                  stage_scan_event_in,
	input wire logic                  scan_request_out,
	input wire logic                  low_power_enable_out,
	input wire logic                  stage3_allowed_out,
	input wire logic                  comp_active_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	// shadow of the control byte as written
	logic [7:0] misc;
	always_ff @(posedge clk_sys_in or posedge reset_in)
		if (reset_in)
			misc <= 8'h00;
		else if (reg_req_in.wr && reg_req_in.addr == ADDR_MISC)
			misc <= reg_req_in.wdata & MISC_WR_MASK;

	a_read_answer: assert property (1'b1 |=>
		reg_rvalid_out == $past(reg_req_in.rd)) else $error("rvalid wrong");
	a_misc_readback: assert property (reg_req_in.rd &&
		(reg_req_in.addr == ADDR_MISC || reg_req_in.addr == 8'had)
		|=> reg_rdata_out == $past(misc)) else $error("misc readback");
	a_rdata_hold: assert property (!reg_req_in.rd |=>
		$stable(reg_rdata_out)) else $error("rdata moved");
	a_lp_follows: assert property (low_power_enable_out == misc[3])
		else $error("low power bit");
	a_stage3_gate: assert property (stage3_allowed_out ==
		(solar_powered_in ? misc[1] : misc[2])) else $error("stage3 gate");
	a_comp_gate: assert property (comp_active_out == (misc[0] &&
		stage_in inside {STG_S2, STG_S3})) else $error("comp gate");
	a_no_scan_dc: assert property (!solar_powered_in &&
		!$past(solar_powered_in) |-> !scan_request_out)
		else $error("scan on dc");
	a_event_scan: assert property (solar_powered_in &&
		stage_scan_event_in |=> scan_request_out) else $error("no event scan");

	c_scan: cover property (scan_request_out);
	c_read: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);
	c_s3: cover property (stage3_allowed_out && solar_powered_in);
endmodule

bind ccfg_top ccfg_properties #(.SCAN_CYCLES(SCAN_CYCLES)) ccfg_properties_inst
(
	.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(reg_req_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.solar_powered_in(solar_powered_in), .stage_in(stage_in),
	.stage_scan_event_in(stage_scan_event_in),
	.scan_request_out(scan_request_out),
	.low_power_enable_out(low_power_enable_out),
	.stage3_allowed_out(stage3_allowed_out),
	.comp_active_out(comp_active_out)
);

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
	import ccfg_pkg::*;
	localparam int SC = 4;
	logic        clk_sys_in, reset_in, solar, event_in, scan, lp, s3, comp;
	logic        rvalid;
	logic [7:0]  r, e, p, q;
	logic [15:0] v2, v3, fac;
	logic [31:0] w;
	int          fail_count, cmp_count, n;
	ccfg_stage_e stage_in;
	ccfg_req_s   req;
	ccfg_coeff_s coeff;
	logic [7:0]  rdata;
	ccfg_volt_s  volt;
	logic        pin;
	logic [15:0] f, s2v, s3v, rv;
	logic [31:0] dt;
	int          hi;
	ccfg_stage_e st [6] = '{STG_UV, STG_S0, STG_S1, STG_S2, STG_S3, STG_DONE};

	ccfg_top #(.SCAN_CYCLES(SC)) ccfg_top_inst
	(
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_req_in(req),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.solar_powered_in(solar), .stage_in(stage_in),
		.stage_scan_event_in(event_in), .stage2_voltage_at_25c_in(v2),
		.stage3_voltage_at_25c_in(v3), .temperature_scale_factor_in(fac),
		.scan_request_out(scan), .low_power_enable_out(lp),
		.stage3_allowed_out(s3), .comp_active_out(comp),
		.coeff_out(coeff), .volt_out(volt),
		.battery_feedback_adjust_pin_out(pin)
	);
	ccfg_host_model h (.clk_in(clk_sys_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .req_out(req));

	// clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	// compare and count
	task automatic check(input string s, input logic [31:0] x,
		input logic [31:0] y);
		cmp_count++;
		if (y !== x)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", s, x, y);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// control byte as it should read back
	function automatic logic [7:0] misc_exp(input logic [7:0] d);
		if (d[4])
			d[2:1] = 2'b00;
		return d & 8'h1f;
	endfunction

	// 25 C target times factor, saturating at full scale
	function automatic logic [15:0] scl(input logic [15:0] v,
		input logic [15:0] k);
		logic [31:0] m;
		m = 32'(v) * 32'(k);
		return m >= 32'h4000_0000 ? 16'hffff : 16'(m >> FACTOR_FRAC);
	endfunction

	// percentage of a reference voltage
	function automatic logic [15:0] pcn(input logic [15:0] v,
		input logic [6:0] k);
		return 16'((32'(v) * 32'(k)) / 32'(PCT_FULL));
	endfunction

	// cycles to the next scan pulse, 300 means none
	task automatic next_scan();
		n = 0;
		do
		begin
			@(negedge clk_sys_in);
			n++;
		end
		while (scan !== 1'b1 && n < 300);
	endtask

	// watchdog
	initial
	begin
		#2000000;
		fail_count++;
		results();
	end

	initial
	begin
		{reset_in, solar, event_in, fail_count, cmp_count} = '0;
		reset_in = 1'b1;
		stage_in = STG_UV;
		void'($urandom(28));
		{v2, v3, fac} = {$urandom, $urandom};
		repeat (6) @(negedge clk_sys_in);
		reset_in = 1'b0;
		// reset values, direct and boot address
		for (int a = 'h4b; a <= 'h5a; a++)
		begin
			h.read(8'(a), r);
			check("reset", 8'h00, r);
			h.read(8'(a + 'h60), r);
			check("boot", 8'h00, r);
		end
		// control byte versus supply and stage
		for (int i = 0; i < 12; i++)
		begin
			e = (i == 0) ? 8'hff : 8'($urandom);
			h.write(ADDR_MISC, e);
			e = misc_exp(e);
			h.read(i[0] ? ADDR_MISC : ADDR_MISC + BOOT_OFFSET, r);
			check("misc", e, r);
			check("lp", e[3], lp);
			for (int k = 0; k < 6; k++)
			begin
				solar = k[0];
				stage_in = st[k];
				@(negedge clk_sys_in);
				check("s3", k[0] ? e[1] : e[2], s3);
				check("comp", e[0] && k inside {3, 4}, comp);
			end
		end
		// coefficients, little endian bytes
		for (int k = 0; k < 3; k++)
		begin
			w = $urandom;
			for (int b = 0; b < 4; b++)
				h.write(ADDR_TC3 + 8'(4 * k + b), w[8 * b +: 8]);
			for (int b = 0; b < 4; b++)
			begin
				h.read(ADDR_TC3 + BOOT_OFFSET + 8'(4 * k + b), r);
				check("coeff byte", w[8 * b +: 8], r);
			end
			check("coeff", w, coeff[32 * (2 - k) +: 32]);
		end
		h.write(ADDR_LP_SCAN + BOOT_OFFSET, 8'h55);
		h.read(ADDR_LP_SCAN, r);
		check("boot write", 8'h00, r);
		// timed scans
		p = 8'($urandom_range(4, 1));
		q = 8'($urandom_range(6, 2));
		h.write(ADDR_SCAN, p);
		h.write(ADDR_LP_SCAN, q);
		h.write(ADDR_MISC, 8'h00);
		solar = 1'b1;
		repeat (3) next_scan();
		check("solar gap", p * SC, n);
		h.write(ADDR_MISC, 8'h08);
		repeat (3) next_scan();
		check("lp gap", q * SC, n);
		h.write(ADDR_LP_SCAN, 8'h00);
		repeat (2) next_scan();
		check("lp zero", 300, n);
		h.write(ADDR_MISC, 8'h00);
		h.write(ADDR_SCAN, 8'h00);
		repeat (2) next_scan();
		check("solar zero", 300, n);
		event_in = 1'b1;
		@(negedge clk_sys_in);
		event_in = 1'b0;
		check("event scan", 1, scan);
		// dc supply: nothing scans
		h.write(ADDR_SCAN, p);
		solar = 1'b0;
		event_in = 1'b1;
		@(negedge clk_sys_in);
		event_in = 1'b0;
		next_scan();
		check("dc scan", 300, n);
		// voltage targets, thresholds and feedback pwm
		stage_in = STG_S2;
		for (int i = 0; i < 4; i++)
		begin
			e = {3'h0, i[1], 3'h0, i[0]};
			h.write(ADDR_MISC, e);
			@(negedge clk_sys_in);
			f = e[BIT_TC_EN] ? fac : FACTOR_ONE;
			s2v = scl(v2, f);
			s3v = scl(v3, f);
			rv = e[BIT_RED_S2] ? s3v : s2v;
			check("stage2 target", rv, volt.stage2_target);
			check("stage3 target", s3v, volt.stage3_target);
			check("s1 to s2", pcn(rv, PCT_UP), volt.s1_to_s2);
			check("s2 to s1", pcn(rv, PCT_DOWN), volt.s2_to_s1);
			check("base ref", s2v, volt.base_ref);
			hi = 0;
			repeat (256)
			begin
				@(negedge clk_sys_in);
				hi += pin;
			end
			dt = (32'(DUTY_NOMINAL) * 32'(f)) >> FACTOR_FRAC;
			check("pwm duty", dt > 32'hff ? 32'hff : dt, hi);
		end
		results();
	end
endmodule
